// ==== hdl/rbk_pkg.sv ====
// Package for the data register bank: address map, field layout and reset values
package rbk_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned CODE_W     = 12;
  localparam int unsigned NUM_ADC    = 16;
  localparam int unsigned NUM_DAC    = 12;
  localparam int unsigned NUM_PIN    = 8;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [6:0] ADC_RESULT_FIRST   = 7'h23;
  localparam logic [6:0] ADC_RESULT_LAST    = 7'h32;
  localparam logic [6:0] OUT_CODE_FIRST     = 7'h33;
  localparam logic [6:0] OUT_CODE_LAST      = 7'h3E;
  localparam logic [6:0] CLEAR_LEVEL_FIRST  = 7'h3F;
  localparam logic [6:0] CLEAR_LEVEL_LAST   = 7'h4A;
  localparam logic [6:0] GENERAL_PIN_PORT   = 7'h4B;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CODE_MSB          = 11;
  localparam int unsigned PIN_MSB           = 7;
  localparam logic [11:0] CODE_RST          = 12'h000;
  localparam logic [7:0]  PIN_PORT_RST      = 8'hFF;
  localparam logic [15:0] READ_UNMAPPED     = 16'h0000;

  // Pins given up to the remote sensors while those are enabled
  localparam logic [7:0]  SENSOR_ONE_PINS   = 8'h30;
  localparam logic [7:0]  SENSOR_TWO_PINS   = 8'hC0;

  // Differential pairs deliver their result into the lower channel
  localparam logic [3:0]  PAIR01_TARGET     = 4'h0;
  localparam logic [3:0]  PAIR23_TARGET     = 4'h2;

endpackage : rbk_pkg

// ==== hdl/rbk_data_regs.sv ====
// Data register bank: conversion results, output codes, clear levels, pin port
//
// Overview of operation
// - Result registers are read-only, twelve low bits hold data, upper bits zero, reset zero.
// - Channel n result lives at address 23h plus n, through 32h.
// - Single-ended results are stored as unsigned straight binary in their own register.
// - Pair zero/one stores a two's complement result in the channel zero register.
// - Pair two/three stores a two's complement result in the channel two register.
// - Twelve output code registers at 33h..3Eh feed each converter's output latch.
// - Output code registers are read/write, twelve-bit unsigned, reset to zero.
// - Clear-level registers at 3Fh..4Ah reset zero and load the latch on clear.
// - Writing zero to pin port bit n drives pin n low.
// - Writing one to pin port bit n releases pin n to high impedance.
// - Reading the pin port returns the levels sensed on the pins.
// - Any reset sets all pin port bits to one, all pins released.
// - With remote sensor one enabled, pin bits four and five are ignored.
// - With remote sensor two enabled, pin bits six and seven are ignored.
// - In direct mode a result register read clears the data available flag.
module rbk_data_regs
  import rbk_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          soft_rst,
  // Register port from the serial interface
  input  wire logic [ADDR_W-1:0]             reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic [DATA_W-1:0]             reg_wr_data,
  input  wire logic                          reg_rd_en,
  output logic      [DATA_W-1:0]             reg_rd_data,
  output logic                               reg_rd_valid,
  // Conversion sequencer
  input  wire logic                          conv_valid,
  input  wire logic [3:0]                    conv_chan,
  input  wire logic [CODE_W-1:0]             conv_data,
  input  wire logic                          diff_pair01,
  input  wire logic                          diff_pair23,
  input  wire logic                          direct_mode,
  input  wire logic                          conv_set_done,
  input  wire logic                          flag_clear,
  output logic                               data_available_flag,
  // Output latch control
  input  wire logic [NUM_DAC-1:0]            latch_load,
  input  wire logic [NUM_DAC-1:0]            latch_clear,
  output logic      [NUM_DAC-1:0][CODE_W-1:0] out_code,
  output logic      [NUM_DAC-1:0][CODE_W-1:0] clear_level,
  output logic      [NUM_DAC-1:0][CODE_W-1:0] latch_code,
  // Remote sensor enables
  input  wire logic                          remote_sensor_one_en,
  input  wire logic                          remote_sensor_two_en,
  // Open-drain general-purpose pins
  input  wire logic [NUM_PIN-1:0]            pin_in,
  output logic      [NUM_PIN-1:0]            pin_out,
  output logic      [NUM_PIN-1:0]            pin_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NUM_ADC-1:0][CODE_W-1:0] adc_result;
    logic [NUM_DAC-1:0][CODE_W-1:0] code;
    logic [NUM_DAC-1:0][CODE_W-1:0] clr_level;
    logic [NUM_DAC-1:0][CODE_W-1:0] latch;
    logic [NUM_PIN-1:0]             pin_port;
    logic [NUM_PIN-1:0]             pin_sync1;
    logic [NUM_PIN-1:0]             pin_sync2;
    logic                           flag;
    logic [DATA_W-1:0]              rd_data;
    logic                           rd_valid;
  } rbk_state_s;

  rbk_state_s state_q;
  rbk_state_s state_d;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic in_range(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] first,
                                    input logic [ADDR_W-1:0] last);
    in_range = (addr >= first) && (addr <= last);
  endfunction

  function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] addr,
                                         input logic [ADDR_W-1:0] first);
    logic [ADDR_W-1:0] diff;
    diff    = addr - first;
    slot_of = diff[3:0];
  endfunction

  // Zero-extend a twelve-bit code into a register word
  function automatic logic [DATA_W-1:0] widen(input logic [CODE_W-1:0] code);
    widen = {{(DATA_W-CODE_W){1'b0}}, code};
  endfunction

  // Pins currently owned by the remote sensors
  function automatic logic [NUM_PIN-1:0] sensor_mask(input logic one_en,
                                                     input logic two_en);
    sensor_mask = (one_en ? SENSOR_ONE_PINS : 8'h00) |
                  (two_en ? SENSOR_TWO_PINS : 8'h00);
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [NUM_PIN-1:0] pin_ignored;
  logic               rd_result;
  logic [3:0]         tgt;
  logic [CODE_W-1:0]  tgt_code;
  logic [DATA_W-1:0]  rd_word;

  always_comb begin
    state_d     = state_q;
    pin_ignored = sensor_mask(remote_sensor_one_en, remote_sensor_two_en);
    rd_result   = reg_rd_en && in_range(reg_addr, ADC_RESULT_FIRST, ADC_RESULT_LAST);
    tgt         = conv_chan;
    tgt_code    = conv_data;
    rd_word     = READ_UNMAPPED;

    // Pin synchroniser; only the second stage is read
    state_d.pin_sync1 = pin_in;
    state_d.pin_sync2 = state_q.pin_sync1;

    // Result capture. The converter code is offset binary, so a differential
    // result becomes two's complement by flipping its top bit.
    if (diff_pair01 && (conv_chan == 4'h0 || conv_chan == 4'h1)) begin
      tgt      = PAIR01_TARGET;
      tgt_code = {~conv_data[CODE_MSB], conv_data[CODE_MSB-1:0]};
    end else if (diff_pair23 && (conv_chan == 4'h2 || conv_chan == 4'h3)) begin
      tgt      = PAIR23_TARGET;
      tgt_code = {~conv_data[CODE_MSB], conv_data[CODE_MSB-1:0]};
    end
    if (conv_valid) begin
      state_d.adc_result[tgt] = tgt_code;
    end

    // Register writes; result registers take no write
    if (reg_wr_en) begin
      if (in_range(reg_addr, OUT_CODE_FIRST, OUT_CODE_LAST)) begin
        state_d.code[slot_of(reg_addr, OUT_CODE_FIRST)] = reg_wr_data[CODE_MSB:0];
      end else if (in_range(reg_addr, CLEAR_LEVEL_FIRST, CLEAR_LEVEL_LAST)) begin
        state_d.clr_level[slot_of(reg_addr, CLEAR_LEVEL_FIRST)] =
          reg_wr_data[CODE_MSB:0];
      end else if (reg_addr == GENERAL_PIN_PORT) begin
        // Bits owned by an enabled remote sensor keep their old value
        state_d.pin_port = (reg_wr_data[PIN_MSB:0] & ~pin_ignored) |
                           (state_q.pin_port & pin_ignored);
      end
    end

    // Output latches: a clear takes priority over a load
    for (int i = 0; i < NUM_DAC; i++) begin
      if (latch_clear[i]) begin
        state_d.latch[i] = state_q.clr_level[i];
      end else if (latch_load[i]) begin
        state_d.latch[i] = state_q.code[i];
      end
    end

    // Data available flag: a new direct-mode completion wins over a result read or flag_clear
    if ((rd_result && direct_mode) || flag_clear || !direct_mode) begin
      state_d.flag = 1'b0;
    end
    if (conv_set_done && direct_mode) begin
      state_d.flag = 1'b1;
    end

    // Read path
    if (in_range(reg_addr, ADC_RESULT_FIRST, ADC_RESULT_LAST)) begin
      rd_word = widen(state_q.adc_result[slot_of(reg_addr, ADC_RESULT_FIRST)]);
    end else if (in_range(reg_addr, OUT_CODE_FIRST, OUT_CODE_LAST)) begin
      rd_word = widen(state_q.code[slot_of(reg_addr, OUT_CODE_FIRST)]);
    end else if (in_range(reg_addr, CLEAR_LEVEL_FIRST, CLEAR_LEVEL_LAST)) begin
      rd_word = widen(state_q.clr_level[slot_of(reg_addr, CLEAR_LEVEL_FIRST)]);
    end else if (reg_addr == GENERAL_PIN_PORT) begin
      rd_word = {{(DATA_W-NUM_PIN){1'b0}}, state_q.pin_sync2};
    end
    state_d.rd_valid = reg_rd_en;
    if (reg_rd_en) begin
      state_d.rd_data = rd_word;
    end

    // Software reset returns every register to its reset value
    if (soft_rst) begin
      state_d.adc_result = '0;
      state_d.code       = '0;
      state_d.clr_level  = '0;
      state_d.latch      = '0;
      state_d.pin_port   = PIN_PORT_RST;
      state_d.flag       = 1'b0;
      state_d.rd_data    = '0;
      state_d.rd_valid   = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q            <= '0;
      state_q.pin_port   <= PIN_PORT_RST;
    end else begin
      state_q            <= state_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Open drain: a zero bit pulls low, a one bit releases the pin
  assign pin_out             = '0;
  assign pin_oe              = ~state_q.pin_port & ~pin_ignored;
  assign reg_rd_data         = state_q.rd_data;
  assign reg_rd_valid        = state_q.rd_valid;
  assign data_available_flag = state_q.flag;
  assign out_code            = state_q.code;
  assign clear_level         = state_q.clr_level;
  assign latch_code          = state_q.latch;

endmodule // rbk_data_regs

// ==== dv/rbk_checker.sv ====
// Concurrent checks on the data register bank ports
module rbk_checker
  import rbk_pkg::*;
(
  input wire logic                            ref_clk,
  input wire logic                            rst,
  input wire logic                            soft_rst,
  input wire logic [ADDR_W-1:0]               reg_addr,
  input wire logic                            reg_wr_en,
  input wire logic [DATA_W-1:0]               reg_wr_data,
  input wire logic                            reg_rd_en,
  input wire logic [DATA_W-1:0]               reg_rd_data,
  input wire logic                            reg_rd_valid,
  input wire logic                            direct_mode,
  input wire logic                            conv_set_done,
  input wire logic                            data_available_flag,
  input wire logic [NUM_DAC-1:0]              latch_clear,
  input wire logic [NUM_DAC-1:0][CODE_W-1:0]  clear_level,
  input wire logic [NUM_DAC-1:0][CODE_W-1:0]  latch_code,
  input wire logic                            remote_sensor_one_en,
  input wire logic                            remote_sensor_two_en,
  input wire logic [NUM_PIN-1:0]              pin_oe
);
  // Soft reset also masks checks, since it overrides any access in flight
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || soft_rst);
  // ****************
  // Assertions
  // ****************
  a_read_answered: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read strobe not answered");
  a_upper_zero: assert property (reg_rd_en
    && reg_addr inside {[ADC_RESULT_FIRST:CLEAR_LEVEL_LAST]}
    |=> reg_rd_data[15:12] == 4'h0) else $error("upper bits not zero");
  a_flag_set_wins: assert property (direct_mode && conv_set_done
    |=> data_available_flag) else $error("flag completion lost");
  a_flag_read_clear: assert property (direct_mode && !conv_set_done && reg_rd_en
    && reg_addr inside {[ADC_RESULT_FIRST:ADC_RESULT_LAST]} |=> !data_available_flag)
    else $error("result read left flag set");
  a_clear_level_wr: assert property (reg_wr_en && reg_addr == CLEAR_LEVEL_LAST
    |=> clear_level[11] == $past(reg_wr_data[11:0])) else $error("clear level not written");
  a_latch_cleared: assert property (latch_clear[0]
    |=> latch_code[0] == $past(clear_level[0])) else $error("latch not loaded on clear");
  a_pin_drive: assert property (reg_wr_en && reg_addr == GENERAL_PIN_PORT
    |=> pin_oe[0] == !$past(reg_wr_data[0])) else $error("pin drive wrong");
  a_sensor_one_pins: assert property (remote_sensor_one_en |-> pin_oe[5:4] == 2'h0)
    else $error("sensor one pins driven");
  a_sensor_two_pins: assert property (remote_sensor_two_en |-> pin_oe[7:6] == 2'h0)
    else $error("sensor two pins driven");
  c_direct_read: cover property (direct_mode && data_available_flag && reg_rd_en);
  c_latch_clear: cover property (latch_clear[0]);
  c_both_sensors: cover property (remote_sensor_one_en && remote_sensor_two_en);
endmodule // rbk_checker

bind rbk_data_regs rbk_checker u_chk (.*);

// ==== dv/tb_top.sv ====
// Self-checking testbench for the data register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rbk_pkg::*;
  logic              ref_clk, rst, soft_rst, reg_wr_en, reg_rd_en, reg_rd_valid, conv_valid;
  logic              diff_pair01, diff_pair23, direct_mode, conv_set_done, flag_clear;
  logic              data_available_flag, remote_sensor_one_en, remote_sensor_two_en;
  logic [6:0]        reg_addr;
  logic [15:0]       reg_wr_data, reg_rd_data;
  logic [3:0]        conv_chan;
  logic [11:0]       conv_data, latch_load, latch_clear;
  logic [11:0][11:0] out_code, clear_level, latch_code;
  logic [7:0]        pin_ext, pin_in, pin_out, pin_oe;
  int                miscompares, num_checks;
  logic [38:0]       rows [4] = '{{7'h33, 16'hF555, 16'h0555}, {7'h3E, 16'h0ABC, 16'h0ABC},
                                  {7'h3F, 16'h12AA, 16'h02AA}, {7'h4A, 16'hFFFF, 16'h0FFF}};
  // Open-drain wire: any pin the bank pulls low reads low
  assign pin_in = pin_ext & ~pin_oe;
  always #25 ref_clk = ~ref_clk;
  rbk_data_regs DUT (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    chk({15'h0, reg_rd_valid}, 16'h0001);
    chk(reg_rd_data, e);
    @(negedge ref_clk);
  endtask
  task automatic conv(input logic [3:0] c, input logic [11:0] d);
    conv_chan = c;
    conv_data = d;
    conv_valid = 1'b1;
    @(negedge ref_clk);
    conv_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {ref_clk, soft_rst, reg_wr_en, reg_rd_en, conv_valid, diff_pair01, diff_pair23} = '0;
    {direct_mode, conv_set_done, flag_clear, remote_sensor_one_en, remote_sensor_two_en} = '0;
    {reg_addr, reg_wr_data, conv_chan, conv_data, latch_load, latch_clear} = '0;
    {miscompares, num_checks} = '0;
    rst = 1'b1;
    pin_ext = 8'hA5;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    chk({8'h0, pin_oe}, 16'h0000);
    foreach (rows[i]) begin
      rd(rows[i][38:32], 16'h0000);
      wr(rows[i][38:32], rows[i][31:16]);
      rd(rows[i][38:32], rows[i][15:0]);
    end
    chk({4'h0, out_code[11]}, 16'h0ABC);
    latch_load = 12'h001;
    @(negedge ref_clk);
    latch_load = 12'h000;
    chk({4'h0, latch_code[0]}, 16'h0555);
    latch_clear = 12'h001;
    @(negedge ref_clk);
    latch_clear = 12'h000;
    chk({4'h0, latch_code[0]}, 16'h02AA);
    $display("Register table test done");
    conv(4'h5, 12'hABC);
    rd(7'h28, 16'h0ABC);
    conv(4'hF, 12'h801);
    wr(ADC_RESULT_LAST, 16'h0000);
    rd(ADC_RESULT_LAST, 16'h0801);
    diff_pair01 = 1'b1;
    diff_pair23 = 1'b1;
    conv(4'h0, 12'h123);
    rd(ADC_RESULT_FIRST, 16'h0923);
    conv(4'h2, 12'hF00);
    rd(7'h25, 16'h0700);
    direct_mode = 1'b1;
    conv_set_done = 1'b1;
    @(negedge ref_clk);
    conv_set_done = 1'b0;
    chk({15'h0, data_available_flag}, 16'h0001);
    rd(7'h24, 16'h0000);
    chk({15'h0, data_available_flag}, 16'h0000);
    conv_set_done = 1'b1;
    flag_clear = 1'b1;
    @(negedge ref_clk);
    conv_set_done = 1'b0;
    chk({15'h0, data_available_flag}, 16'h0001);
    @(negedge ref_clk);
    flag_clear = 1'b0;
    chk({15'h0, data_available_flag}, 16'h0000);
    conv_set_done = 1'b1;
    @(negedge ref_clk);
    conv_set_done = 1'b0;
    direct_mode = 1'b0;
    chk({15'h0, data_available_flag}, 16'h0001);
    @(negedge ref_clk);
    chk({15'h0, data_available_flag}, 16'h0000);
    $display("Conversion test done");
    rd(GENERAL_PIN_PORT, 16'h00A5);
    wr(GENERAL_PIN_PORT, 16'h00FE);
    chk({8'h0, pin_oe}, 16'h0001);
    repeat (2) @(negedge ref_clk);
    rd(GENERAL_PIN_PORT, 16'h00A4);
    wr(GENERAL_PIN_PORT, 16'h0000);
    chk({8'h0, pin_oe}, 16'h00FF);
    chk({8'h0, pin_out}, 16'h0000);
    remote_sensor_one_en = 1'b1;
    @(negedge ref_clk);
    chk({8'h0, pin_oe}, 16'h00CF);
    remote_sensor_two_en = 1'b1;
    @(negedge ref_clk);
    chk({8'h0, pin_oe}, 16'h000F);
    wr(GENERAL_PIN_PORT, 16'h00FF);
    remote_sensor_one_en = 1'b0;
    remote_sensor_two_en = 1'b0;
    @(negedge ref_clk);
    chk({8'h0, pin_oe}, 16'h00F0);
    $display("Pin port test done");
    soft_rst = 1'b1;
    @(negedge ref_clk);
    soft_rst = 1'b0;
    chk({8'h0, pin_oe}, 16'h0000);
    chk({4'h0, clear_level[11]}, 16'h0000);
    chk({4'h0, latch_code[0]}, 16'h0000);
    rd(OUT_CODE_FIRST, 16'h0000);
    rd(ADC_RESULT_LAST, 16'h0000);
    rd(7'h10, READ_UNMAPPED);
    $display("Soft reset test done");
    stop_test();
  end
endmodule // tb_top
